/* rtl/sife_pkg.sv */
// Package for the sync input front end: register map, reset values, pin and state carriers.
// Assumes a 100 MHz CLK and an APB master with 32-bit data.
package sife_pkg;
  localparam int unsigned ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_HPOL = 8'h12;
  localparam logic [7:0] IDX_COAST = 8'h18;
  localparam logic [7:0] IDX_THRESH = 8'h1a;
  localparam logic [7:0] IDX_CHAN = 8'h1b;
  localparam logic [7:0] IDX_STATUS = 8'h1c;
  localparam logic [11:0] ADDR_HPOL = {2'h0, IDX_HPOL, 2'h0};
  localparam logic [11:0] ADDR_COAST = {2'h0, IDX_COAST, 2'h0};
  localparam logic [11:0] ADDR_THRESH = {2'h0, IDX_THRESH, 2'h0};
  localparam logic [11:0] ADDR_CHAN = {2'h0, IDX_CHAN, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  // Field positions
  localparam int unsigned HPOL_LSB = 4;
  localparam int unsigned COAST_LSB = 5;
  localparam int unsigned CNT_LSB = 16;
  // Threshold in millivolts above the negative peak
  localparam int unsigned THRESH_W = 6;
  localparam int unsigned THRESH_STEP_MV = 10;
  localparam int unsigned THRESH_MIN_MV = 10;
  localparam int unsigned THRESH_MAX_MV = 330;
  localparam int unsigned THRESH_DEF_MV = 150;
  localparam logic [5:0] THRESH_MAX = 6'((THRESH_MAX_MV - THRESH_MIN_MV) / THRESH_STEP_MV);
  localparam logic [5:0] THRESH_RST = 6'((THRESH_DEF_MV - THRESH_MIN_MV) / THRESH_STEP_MV);
  // Values after reset
  localparam logic [1:0] HPOL_RST = 2'h0;
  localparam logic [1:0] COAST_POL_RST = 2'h1;
  localparam logic CHAN_RST = 1'b0;

  typedef struct packed {
    logic link_pos;
    logic link_neg;
    logic ext;
    logic [1:0] hs;
    logic [1:0] vs;
    logic [1:0] sog;
  } sife_pins_t;

  typedef struct packed {
    sife_pins_t pin1;
    sife_pins_t pin2;
    logic hs_prev;
    logic link_prev;
    logic [1:0] hpol;
    logic [1:0] cpol;
    logic [5:0] thresh;
    logic chan;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] edge_cnt;
    logic hs_edge;
    logic hs_ref;
    logic vs_out;
    logic sog_out;
    logic pll_track;
    logic pll_edge;
    logic ext_ref;
    logic link_tick;
  } sife_state_t;

  localparam sife_state_t STATE_RST = '{hpol: HPOL_RST, cpol: COAST_POL_RST, thresh: THRESH_RST,
                                         chan: CHAN_RST, pll_track: 1'b1, default: '0};
endpackage

/* rtl/sife_top.sv */
// Sync input front end: sync selection, edge pick, coast gating and APB registers.
// Assumes pins are asynchronous to CLK; the PLL and comparator sit outside.
//
// Behaviour
// RULE_01: Link clock pair serves as pixel-rate reference for the digital receiver.
// RULE_02: Horizontal sync is the timing and pixel clock frequency reference.
// RULE_03: Two-bit field 5:4 of register 0x12 sets horizontal sync sense.
// RULE_04: Only the leading sync edge acts; the trailing edge is ignored.
// RULE_05: Polarity 0 picks the falling edge, polarity 1 the rising edge.
// RULE_06: Green sync threshold 10 to 330 mV in 10 mV steps, 150 mV default.
// RULE_07: Green sync comparator result goes out uninverted as composite sync.
// RULE_08: Active coast stops tracking; generator holds frequency and phase.
// RULE_09: Coast sense is set by field 6:5 of register 0x18.
// RULE_10: Coast polarity comes up as 1 before any write.
// RULE_11: Unused coast pin: ground with polarity 1, or tie high with 0.
// RULE_12: Coast and external clock share a pin without disturbing each other.
// RULE_13: Channel select picks one of two sync channels, ignoring the other.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

module sife_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic [1:0] HSYNC_IN,
  input wire logic [1:0] VSYNC_IN,
  input wire logic [1:0] GREEN_EMBEDDED_SYNC_IN,
  input wire logic EXT_CLOCK_OR_HOLD_IN,
  input wire logic LINK_CLOCK_POS,
  input wire logic LINK_CLOCK_NEG,
  output logic HSYNC_EDGE,
  output logic HSYNC_REF,
  output logic VSYNC_OUT,
  output logic GREEN_EMBEDDED_SYNC_OUT,
  output logic [5:0] SOG_THRESHOLD,
  output logic PLL_TRACK_EN,
  output logic PLL_REF_EDGE,
  output logic EXT_CLOCK_REF,
  output logic LINK_REF_TICK
);

  // Map of readable and writable words
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == sife_pkg::ADDR_HPOL) || (a == sife_pkg::ADDR_COAST) ||
               (a == sife_pkg::ADDR_THRESH) || (a == sife_pkg::ADDR_CHAN) ||
               (a == sife_pkg::ADDR_STATUS);
  endfunction

  sife_pkg::sife_state_t q;
  sife_pkg::sife_state_t next_q;
  sife_pkg::sife_pins_t pins_now;
  logic hs_sel;
  logic vs_sel;
  logic sog_sel;
  logic hs_norm;
  logic coast_act;
  logic apb_acc;
  logic apb_wr;
  logic [31:0] rd_val;

  always_comb begin
    pins_now.link_pos = LINK_CLOCK_POS;
    pins_now.link_neg = LINK_CLOCK_NEG;
    pins_now.ext = EXT_CLOCK_OR_HOLD_IN;
    pins_now.hs = HSYNC_IN;
    pins_now.vs = VSYNC_IN;
    pins_now.sog = GREEN_EMBEDDED_SYNC_IN;
  end

  // Channel mux after the synchronisers
  always_comb begin
    hs_sel = q.chan ? q.pin2.hs[1] : q.pin2.hs[0]; // [RULE_13]
    vs_sel = q.chan ? q.pin2.vs[1] : q.pin2.vs[0]; // [RULE_13]
    sog_sel = q.chan ? q.pin2.sog[1] : q.pin2.sog[0]; // [RULE_13]
    hs_norm = q.hpol[0] ? hs_sel : ~hs_sel; // [RULE_03] [RULE_05]
    coast_act = q.cpol[0] ? q.pin2.ext : ~q.pin2.ext; // [RULE_09] [RULE_11]
  end

  // Read value for the addressed word
  always_comb begin
    rd_val = 32'h0;
    case (PADDR)
      sife_pkg::ADDR_HPOL: rd_val[sife_pkg::HPOL_LSB +: 2] = q.hpol;
      sife_pkg::ADDR_COAST: rd_val[sife_pkg::COAST_LSB +: 2] = q.cpol;
      sife_pkg::ADDR_THRESH: rd_val[sife_pkg::THRESH_W-1:0] = q.thresh;
      sife_pkg::ADDR_CHAN: rd_val[0] = q.chan;
      sife_pkg::ADDR_STATUS: begin
        rd_val[0] = coast_act;
        rd_val[1] = q.hs_ref;
        rd_val[2] = q.vs_out;
        rd_val[3] = q.sog_out;
        rd_val[4] = q.pin2.ext;
        rd_val[sife_pkg::CNT_LSB +: 16] = q.edge_cnt;
      end
      default: rd_val = 32'h0;
    endcase
  end

  assign apb_acc = PSEL && PENABLE;
  assign apb_wr = apb_acc && q.pready && PWRITE && PSTRB[0] && addr_hit(PADDR);

  always_comb begin
    next_q = q;
    // Two-stage synchronisers
    next_q.pin1 = pins_now;
    next_q.pin2 = q.pin1;
    // Link clock reference tick on a valid differential rise
    next_q.link_prev = q.pin2.link_pos;
    next_q.link_tick = q.pin2.link_pos & ~q.pin2.link_neg & ~q.link_prev; // [RULE_01]
    // Leading edge only, in the programmed sense
    next_q.hs_prev = hs_norm;
    next_q.hs_ref = hs_norm; // [RULE_02]
    next_q.hs_edge = hs_norm & ~q.hs_prev; // [RULE_04] [RULE_05]
    if (hs_norm && !q.hs_prev) begin
      next_q.edge_cnt = q.edge_cnt + 16'h1;
    end
    next_q.vs_out = vs_sel;
    next_q.sog_out = sog_sel; // [RULE_07]
    // Coast freezes tracking; the shared pin still feeds the clock path
    next_q.pll_track = ~coast_act; // [RULE_08]
    next_q.pll_edge = hs_norm & ~q.hs_prev & ~coast_act; // [RULE_02] [RULE_08]
    next_q.ext_ref = q.pin2.ext; // [RULE_12]
    // APB: one wait state, then the access completes
    if (apb_acc && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.pslverr = ~addr_hit(PADDR);
      next_q.prdata = rd_val;
    end else begin
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
    end
    if (apb_wr) begin
      case (PADDR)
        sife_pkg::ADDR_HPOL: next_q.hpol = PWDATA[sife_pkg::HPOL_LSB +: 2]; // [RULE_03]
        sife_pkg::ADDR_COAST: next_q.cpol = PWDATA[sife_pkg::COAST_LSB +: 2]; // [RULE_09]
        sife_pkg::ADDR_THRESH: begin
          if (PWDATA[5:0] > sife_pkg::THRESH_MAX) begin
            next_q.thresh = sife_pkg::THRESH_MAX; // [RULE_06]
          end else begin
            next_q.thresh = PWDATA[5:0]; // [RULE_06]
          end
        end
        sife_pkg::ADDR_CHAN: next_q.chan = PWDATA[0]; // [RULE_13]
        default: next_q.chan = q.chan;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      q <= sife_pkg::STATE_RST; // [RULE_06] [RULE_10]
    end else begin
      q <= next_q;
    end
  end

  assign PREADY = q.pready;
  assign PRDATA = q.prdata;
  assign PSLVERR = q.pslverr;
  assign HSYNC_EDGE = q.hs_edge;
  assign HSYNC_REF = q.hs_ref;
  assign VSYNC_OUT = q.vs_out;
  assign GREEN_EMBEDDED_SYNC_OUT = q.sog_out;
  assign SOG_THRESHOLD = q.thresh;
  assign PLL_TRACK_EN = q.pll_track;
  assign PLL_REF_EDGE = q.pll_edge;
  assign EXT_CLOCK_REF = q.ext_ref;
  assign LINK_REF_TICK = q.link_tick;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence hpol_write_s;
    PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && PADDR == sife_pkg::ADDR_HPOL;
  endsequence

  sequence steady_cfg_s;
    $stable(q.hpol) && $stable(q.chan);
  endsequence

  link_tick_a: assert property ( // [RULE_01]
    (q.pin2.link_pos && !q.link_prev && !q.pin2.link_neg) |=> LINK_REF_TICK)
    else $error("Link reference tick missing");

  hsync_ref_a: assert property ( // [RULE_02]
    1'b1 |=> (HSYNC_REF == $past(hs_norm)) && (!PLL_REF_EDGE || HSYNC_EDGE))
    else $error("Sync reference does not follow input");

  hpol_write_a: assert property ( // [RULE_03]
    hpol_write_s |=> q.hpol == $past(PWDATA[5:4]))
    else $error("Polarity field not written");

  lead_only_a: assert property ( // [RULE_04]
    HSYNC_EDGE |-> HSYNC_REF ##1 !HSYNC_EDGE)
    else $error("Edge pulse on trailing edge");

  edge_sense_a: assert property ( // [RULE_05]
    (($changed(hs_sel) && hs_sel == q.hpol[0]) and steady_cfg_s) |=> HSYNC_EDGE)
    else $error("Active edge not taken");

  sog_default_a: assert property (disable iff (1'b0) // [RULE_06]
    !RSTN |=> SOG_THRESHOLD == sife_pkg::THRESH_RST && SOG_THRESHOLD <= sife_pkg::THRESH_MAX)
    else $error("Threshold default wrong");

  sog_pass_a: assert property ( // [RULE_07]
    1'b1 |=> GREEN_EMBEDDED_SYNC_OUT == $past(sog_sel))
    else $error("Green sync output not passed through");

  coast_hold_a: assert property ( // [RULE_08]
    coast_act |=> !PLL_TRACK_EN && !PLL_REF_EDGE)
    else $error("Tracking not frozen under coast");

  coast_sense_a: assert property ( // [RULE_09]
    (q.cpol[0] != q.pin2.ext) |=> PLL_TRACK_EN)
    else $error("Coast sense wrong");

  cpol_reset_a: assert property (disable iff (1'b0) // [RULE_10]
    !RSTN |=> q.cpol == sife_pkg::COAST_POL_RST)
    else $error("Coast polarity reset wrong");

  ext_indep_a: assert property ( // [RULE_12]
    1'b1 |=> EXT_CLOCK_REF == $past(q.pin2.ext))
    else $error("Clock path disturbed by coast");

  chan_sel_a: assert property ( // [RULE_13]
    1'b1 |=> VSYNC_OUT == $past(vs_sel) && $past(vs_sel) == $past(q.pin2.vs[q.chan]))
    else $error("Wrong channel selected");

  sequence apb_first_s;
    PSEL && PENABLE && !PREADY;
  endsequence

  sequence coast_write_s;
    PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && PADDR == sife_pkg::ADDR_COAST;
  endsequence

  apb_ready_a: assert property ( // [RULE_03]
    apb_first_s |=> PREADY ##1 !PREADY)
    else $error("Access not answered in one wait state");

  cpol_write_a: assert property ( // [RULE_09]
    coast_write_s |=> q.cpol == $past(PWDATA[6:5]))
    else $error("Coast polarity field not written");

  strobe_off_a: assert property ( // [RULE_03]
    (PSEL && PENABLE && PREADY && PWRITE && !PSTRB[0]) |=> $stable(q.hpol) && $stable(q.cpol))
    else $error("Write without byte strobe took effect");

  thresh_clamp_a: assert property ( // [RULE_06]
    1'b1 |-> SOG_THRESHOLD <= sife_pkg::THRESH_MAX)
    else $error("Threshold above top step");

  edge_count_a: assert property ( // [RULE_04]
    HSYNC_EDGE |-> q.edge_cnt == $past(q.edge_cnt) + 16'h1)
    else $error("Edge count not advanced");

  trail_quiet_a: assert property ( // [RULE_04]
    (q.hs_prev && !hs_norm) |=> !HSYNC_EDGE && !PLL_REF_EDGE)
    else $error("Trailing edge produced a pulse");

  pll_edge_a: assert property ( // [RULE_08]
    1'b1 |-> PLL_REF_EDGE == (HSYNC_EDGE && PLL_TRACK_EN))
    else $error("Tracking edge not gated by coast");

  chan_ignore_a: assert property ( // [RULE_13]
    ($stable(q.chan) && !q.chan && $stable(q.pin2.vs[0])) |=> $stable(VSYNC_OUT))
    else $error("Other channel reached output");

  link_gap_a: assert property ( // [RULE_01]
    !q.pin2.link_pos |=> !LINK_REF_TICK)
    else $error("Link tick without rise");

  cfg_reset_a: assert property (disable iff (1'b0) // [RULE_03]
    !RSTN |=> q.hpol == sife_pkg::HPOL_RST && q.chan == sife_pkg::CHAN_RST)
    else $error("Polarity or channel reset wrong");

endmodule

/* dv/sife_src_model.sv */
// Sync source model: drives sync pins, shared pin and a gated link clock pair.
// Assumes CLK is the receiver clock; pins change just after its rising edges.
`timescale 1ns/100ps
module sife_src_model (
  input wire logic CLK,
  output logic [1:0] hs,
  output logic [1:0] vs,
  output logic [1:0] sog,
  output logic ext,
  output logic lpos,
  output logic lneg
);
  initial begin
    {hs, vs, sog, ext, lpos} = '0;
    lneg = 1'b1;
  end
  // Shared pin high stands for tied-high use with coast polarity 0
  task automatic pins(input logic [1:0] h, input logic [1:0] v, input logic [1:0] s, input logic e);
    @(posedge CLK);
    {hs, vs, sog, ext} <= {h, v, s, e};
  endtask
  // Link clock at one tick per pixel, idle between bursts
  task automatic link(input int n);
    repeat (n) begin
      @(posedge CLK);
      {lpos, lneg} <= 2'h2;
      repeat (4) @(posedge CLK);
      {lpos, lneg} <= 2'h1;
      repeat (3) @(posedge CLK);
    end
  endtask
endmodule

/* dv/sife_top_tb_top.sv */
// Testbench for the sync input front end: APB tasks and pin scenarios.
// Assumes the source model drives all sync pins; PSTRB is held at all ones.
`timescale 1ns/100ps
module sife_top_tb_top;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] PSTRB;
  logic HSYNC_EDGE, HSYNC_REF, VSYNC_OUT, SOG_OUT, PLL_TRACK_EN, PLL_REF_EDGE, EXT_CLOCK_REF, LINK_REF_TICK;
  logic [5:0] SOG_THRESHOLD;
  logic [1:0] hs, vs, sog;
  logic ext, lpos, lneg;
  logic [31:0] tw[3] = '{32'h0, 32'h20, 32'h28};
  logic [31:0] te[3] = '{32'h0, 32'h20, 32'h20};
  int fails = 0, total_checks = 0, n_edge = 0, n_pll = 0, n_tick = 0, e0, p0;
  sife_src_model u_sife_src_model (.CLK(CLK), .hs(hs), .vs(vs), .sog(sog), .ext(ext), .lpos(lpos), .lneg(lneg));
  sife_top u_sife_top (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .HSYNC_IN(hs),
    .VSYNC_IN(vs), .GREEN_EMBEDDED_SYNC_IN(sog), .EXT_CLOCK_OR_HOLD_IN(ext), .LINK_CLOCK_POS(lpos),
    .LINK_CLOCK_NEG(lneg), .HSYNC_EDGE(HSYNC_EDGE), .HSYNC_REF(HSYNC_REF), .VSYNC_OUT(VSYNC_OUT),
    .GREEN_EMBEDDED_SYNC_OUT(SOG_OUT), .SOG_THRESHOLD(SOG_THRESHOLD), .PLL_TRACK_EN(PLL_TRACK_EN),
    .PLL_REF_EDGE(PLL_REF_EDGE), .EXT_CLOCK_REF(EXT_CLOCK_REF), .LINK_REF_TICK(LINK_REF_TICK));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Pulse counters
  always @(posedge CLK) begin
    n_edge <= n_edge + 32'(HSYNC_EDGE === 1'b1);
    n_pll <= n_pll + 32'(PLL_REF_EDGE === 1'b1);
    n_tick <= n_tick + 32'(LINK_REF_TICK === 1'b1);
  end
  task automatic report_and_stop();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(negedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (PREADY !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = PRDATA;
    err = PSLVERR;
    @(posedge CLK);
    {PSEL, PENABLE} <= 2'h0;
  endtask
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    PSTRB = 4'hf;
    RSTN = 1'b0;
    cyc(10);
    RSTN <= 1'b1;
    apb(1'b0, sife_pkg::ADDR_HPOL, 32'h0);
    chk("hpol reset", 32'h0, rd);
    apb(1'b0, sife_pkg::ADDR_COAST, 32'h0);
    chk("coast pol reset", 32'h20, rd);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("thresh reset pin", 32'he, {26'h0, SOG_THRESHOLD});
    foreach (tw[i]) begin
      apb(1'b1, sife_pkg::ADDR_THRESH, tw[i]);
      apb(1'b0, sife_pkg::ADDR_THRESH, 32'h0);
      chk("thresh read", te[i], rd);
      chk("thresh pin", te[i], {26'h0, SOG_THRESHOLD});
    end
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, sife_pkg::ADDR_HPOL, 32'(p) << 4);
      u_sife_src_model.pins(p ? 2'h0 : 2'h3, 2'h0, 2'h0, 1'b0);
      cyc(6);
      e0 = n_edge;
      u_sife_src_model.pins(p ? 2'h3 : 2'h0, 2'h0, 2'h0, 1'b0);
      cyc(6);
      chk("leading edge", 32'h1, n_edge - e0);
      chk("hsync ref", 32'h1, {31'h0, HSYNC_REF});
      e0 = n_edge;
      u_sife_src_model.pins(p ? 2'h0 : 2'h3, 2'h0, 2'h0, 1'b0);
      cyc(6);
      chk("trailing edge", 32'h0, n_edge - e0);
    end
    u_sife_src_model.pins(2'h0, 2'h0, 2'h0, 1'b1);
    cyc(6);
    chk("coast track", 32'h0, {31'h0, PLL_TRACK_EN});
    chk("ext ref", 32'h1, {31'h0, EXT_CLOCK_REF});
    {e0, p0} = {n_edge, n_pll};
    u_sife_src_model.pins(2'h3, 2'h0, 2'h0, 1'b1);
    cyc(6);
    chk("edge in coast", 32'h1, n_edge - e0);
    chk("pll edge in coast", 32'h0, n_pll - p0);
    apb(1'b1, sife_pkg::ADDR_COAST, 32'h0);
    u_sife_src_model.pins(2'h0, 2'h0, 2'h0, 1'b1);
    cyc(6);
    chk("coast pol 0", 32'h1, {31'h0, PLL_TRACK_EN});
    p0 = n_pll;
    u_sife_src_model.pins(2'h3, 2'h0, 2'h0, 1'b1);
    cyc(6);
    chk("pll edge tracking", 32'h1, n_pll - p0);
    u_sife_src_model.pins(2'h0, 2'h2, 2'h2, 1'b0);
    cyc(6);
    chk("chan 0 sog", 32'h0, {31'h0, SOG_OUT});
    chk("chan 0 vsync", 32'h0, {31'h0, VSYNC_OUT});
    apb(1'b1, sife_pkg::ADDR_CHAN, 32'h1);
    cyc(6);
    chk("chan 1 sog", 32'h1, {31'h0, SOG_OUT});
    chk("chan 1 vsync", 32'h1, {31'h0, VSYNC_OUT});
    e0 = n_edge;
    u_sife_src_model.pins(2'h1, 2'h2, 2'h2, 1'b0);
    cyc(6);
    chk("other chan edge", 32'h0, n_edge - e0);
    u_sife_src_model.pins(2'h3, 2'h2, 2'h2, 1'b0);
    cyc(6);
    chk("own chan edge", 32'h1, n_edge - e0);
    e0 = n_tick;
    u_sife_src_model.link(5);
    cyc(6);
    chk("link ticks", 32'h5, n_tick - e0);
    report_and_stop();
  end
endmodule
